// ---- verilog/wps_pkg.sv ----
package wps_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] WPS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] WPS_ADDR_SEG0_ADDR = 4'h1;
  localparam logic [3:0] WPS_ADDR_SEG0_CFG = 4'h2;
  localparam logic [3:0] WPS_ADDR_SEG1_ADDR = 4'h3;
  localparam logic [3:0] WPS_ADDR_SEG1_CFG = 4'h4;
  localparam logic [3:0] WPS_ADDR_STATUS = 4'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WPS_CTRL_EN_BIT = 0;
  localparam int WPS_CTRL_DEST_BIT = 1;
  localparam int WPS_CTRL_OPMODE_LSB = 2;
  localparam int WPS_SEG_START_LSB = 0;
  localparam int WPS_SEG_END_LSB = 16;
  localparam int WPS_SEG_RATE_LSB = 0;
  localparam int WPS_SEG_MODE_LSB = 16;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] WPS_MODE_RAMP_UP = 3'h1;
  localparam logic [2:0] WPS_MODE_BIDIR = 3'h2;
  localparam logic [2:0] WPS_MODE_CONT_BIDIR = 3'h3;
  localparam logic [2:0] WPS_MODE_RECIRC = 3'h4;
  localparam logic [1:0] WPS_OP_QUAD_UPCONVERT = 2'h0;
  localparam logic [1:0] WPS_OP_INTERP = 2'h1;
  localparam logic [31:0] WPS_CTRL_RST = 32'h0;
  localparam logic [15:0] WPS_RATE_RST = 16'h1;
  localparam int WPS_CCI_RATE_DEF = 4;
  localparam int WPS_SYSCLK_PER_DATA = 4;

  typedef struct packed {
    logic [9:0] start_addr;
    logic [9:0] end_addr;
    logic [15:0] step_rate;
    logic [2:0] mode;
  } wps_seg_s;

  typedef struct packed {
    logic enable;
    logic dest_mult;
    logic [1:0] op_mode;
  } wps_ctrl_s;

  typedef enum logic [1:0] {
    WPS_IDLE = 2'b00,
    WPS_ARMED = 2'b01,
    WPS_RUN = 2'b11,
    WPS_HALT = 2'b10
  } wps_state_e;

endpackage

// ---- verilog/wps_sync_edge.sv ----
`timescale 1ns/1ps
module wps_sync_edge
  import wps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule

// ---- verilog/wps_timer.sv ----
`timescale 1ns/1ps
module wps_timer
  import wps_pkg::*;
#(
  parameter int WIDTH = 24
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic run,
  input wire logic [WIDTH-1:0] period,
  output logic tick
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  initial
  begin
    if (WIDTH < 2)
      $error("timer width too small");
  end

  // Period of zero behaves as one so the timer can never stall
  assign tick = run && !restart && (cnt_r + 1'b1 >= period);
  assign cnt_nxt = (restart || tick || !run) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

// ---- verilog/wps_sequencer.sv ----
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
// How it works
// [RULE_01] Each segment has a 3-bit mode: 1 ramp, 2 bidir, 3 cont bidir, 4 recirculate.
// [RULE_02] The mode used is the one in the currently active segment.
// [RULE_03] Playback runs only in quadrature upconvert or interpolating converter mode.
// [RULE_04] Controller avoids continuous modes when multipliers are the destination.
// [RULE_05] Ramp-up: strobe or any trigger edge loads start address and starts. With multiplier destination the strobe only arms here.
// [RULE_06] Ramp-up: address steps by one on each sample timer expiry.
// [RULE_07] Ramp-up: at end address stop and hold it.
// [RULE_08] Sample timer period follows destination and, for multipliers, step rate.
// [RULE_09] Controller programs both segments to bidir code for bidir operation.
// [RULE_10] Bidir: strobe arms with segment 0 but does not step.
// [RULE_11] Bidir: rising edge loads seg 0 start, counts up, halts at end.
// [RULE_12] Bidir: falling edge selects seg 1, loads end, counts down, halts at start.
// [RULE_13] Bidir: edge before terminal restarts timer and reverses direction.
// [RULE_14] Controller loads segment 1 data reversed for bidir mode.
// [RULE_15] Cont bidir: start up from start, reverse at each terminal forever.
// [RULE_16] Cont bidir: trigger edge restarts from new segment start.
// [RULE_17] Recirculate: after end, next expiry jumps to start and continues.
// [RULE_18] Recirculate repeats until strobe or trigger edge restarts it.
// [RULE_19] Rising edge selects segment 0, falling edge selects segment 1.
// [RULE_20] Enable, destination and segment fields take effect only on update.
// [RULE_21] Segment holds 10-bit start, 10-bit end, 16-bit rate, 3-bit mode.
// [RULE_22] Multiplier destination: update drives zero until next trigger edge.
// [RULE_23] Unused mode codes do no stepping and hold output stable.
module wps_sequencer
  import wps_pkg::*;
#(
  parameter int CCI_RATE = WPS_CCI_RATE_DEF,
  parameter int TMR_W = 24
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic io_update,
  input wire logic profile_change,
  input wire logic ram_trigger_pin,
  output logic [9:0] ram_addr,
  output logic ram_rd_en,
  output logic mult_zero,
  output logic dest_mult
);

  initial
  begin
    if (CCI_RATE < 1 || TMR_W < 20)
      $error("sequencer parameters out of range");
  end

  // ----------------------------------------------------------------
  // Staged registers, written by software
  // ----------------------------------------------------------------
  logic [31:0] ctrl_stage_r;
  wps_seg_s seg_stage_r [2];
  logic [31:0] rdata_r;

  // ----------------------------------------------------------------
  // Working copies, loaded on update
  // ----------------------------------------------------------------
  wps_ctrl_s ctrl_r;
  wps_seg_s seg_r [2];
  wps_state_e state_r;
  wps_state_e state_nxt;
  logic active_r;
  logic active_nxt;
  logic up_r;
  logic up_nxt;
  logic [9:0] addr_r;
  logic [9:0] addr_nxt;
  logic zero_r;
  logic zero_nxt;

  wire logic upd = io_update | profile_change;
  wire logic wr_ctrl = reg_wr && (reg_addr == WPS_ADDR_CTRL);
  wire logic wr_s0a = reg_wr && (reg_addr == WPS_ADDR_SEG0_ADDR);
  wire logic wr_s0c = reg_wr && (reg_addr == WPS_ADDR_SEG0_CFG);
  wire logic wr_s1a = reg_wr && (reg_addr == WPS_ADDR_SEG1_ADDR);
  wire logic wr_s1c = reg_wr && (reg_addr == WPS_ADDR_SEG1_CFG);

  // ----------------------------------------------------------------
  // Trigger pin synchroniser
  // ----------------------------------------------------------------
  logic trig_level;
  logic trig_rise;
  logic trig_fall;

  wps_sync_edge u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(ram_trigger_pin),
    .level(trig_level),
    .rise(trig_rise),
    .fall(trig_fall)
  );

  wire logic trig_edge = trig_rise | trig_fall;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m == WPS_MODE_RAMP_UP) || (m == WPS_MODE_BIDIR) ||
                 (m == WPS_MODE_CONT_BIDIR) || (m == WPS_MODE_RECIRC);
  endfunction

  wire logic op_ok = ctrl_r.enable &&
    ((ctrl_r.op_mode == WPS_OP_QUAD_UPCONVERT) ||
     (ctrl_r.op_mode == WPS_OP_INTERP)); // see [RULE_03]
  // Segment chosen by the edge: rising picks 0, falling picks 1
  wire logic edge_seg = trig_fall; // see [RULE_19]
  wire logic [2:0] act_mode = seg_r[active_r].mode; // see [RULE_02]
  wire logic [2:0] new_mode = seg_r[edge_seg].mode;
  wire logic [9:0] act_start = seg_r[active_r].start_addr;
  wire logic [9:0] act_end = seg_r[active_r].end_addr;

  // ----------------------------------------------------------------
  // Sample timer
  // ----------------------------------------------------------------
  // Baseband destination steps every data clock; multiplier path uses 4*R*M
  // sysclks, i.e. R*M data clocks since one data clock is four sysclks.
  logic [TMR_W-1:0] period;
  logic timer_restart;
  logic tick;

  assign period = ctrl_r.dest_mult ?
    TMR_W'(CCI_RATE * int'(seg_r[active_r].step_rate) * WPS_SYSCLK_PER_DATA
           / WPS_SYSCLK_PER_DATA) :
    TMR_W'(1); // see [RULE_08]

  wps_timer #(.WIDTH(TMR_W)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .restart(timer_restart || upd),
    .run(state_r == WPS_RUN),
    .period(period),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Address state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    active_nxt = active_r;
    up_nxt = up_r;
    addr_nxt = addr_r;
    zero_nxt = zero_r;
    timer_restart = 1'b0;
    if (!op_ok)
    begin
      state_nxt = WPS_IDLE;
    end
    else if (trig_edge && mode_valid(new_mode))
    begin
      // An edge whose selected segment holds a valid mode aborts the running waveform and starts that segment
      active_nxt = edge_seg; // see [RULE_19]
      timer_restart = 1'b1; // see [RULE_13]
      zero_nxt = 1'b0; // see [RULE_22]
      state_nxt = WPS_RUN; // see [RULE_05] [RULE_16] [RULE_18]
      if (new_mode == WPS_MODE_BIDIR && edge_seg)
      begin
        addr_nxt = seg_r[1].end_addr; // see [RULE_12]
        up_nxt = 1'b0;
      end
      else
      begin
        addr_nxt = seg_r[edge_seg].start_addr; // see [RULE_11] [RULE_15]
        up_nxt = 1'b1;
      end
    end
    else if (tick && mode_valid(act_mode)) // see [RULE_23]
    begin
      case (act_mode)
        WPS_MODE_RAMP_UP:
        begin
          if (addr_r == act_end)
            state_nxt = WPS_HALT; // see [RULE_07]
          else
            addr_nxt = addr_r + 10'h1; // see [RULE_06]
        end
        WPS_MODE_BIDIR:
        begin
          if (up_r && addr_r != act_end)
            addr_nxt = addr_r + 10'h1; // see [RULE_11]
          else if (!up_r && addr_r != act_start)
            addr_nxt = addr_r - 10'h1; // see [RULE_12]
          else
            state_nxt = WPS_HALT;
        end
        WPS_MODE_CONT_BIDIR:
        begin
          if (up_r && addr_r == act_end)
          begin
            up_nxt = 1'b0;
            addr_nxt = addr_r - 10'h1; // see [RULE_15]
          end
          else if (!up_r && addr_r == act_start)
          begin
            up_nxt = 1'b1;
            addr_nxt = addr_r + 10'h1;
          end
          else
            addr_nxt = up_r ? addr_r + 10'h1 : addr_r - 10'h1;
        end
        WPS_MODE_RECIRC:
        begin
          if (addr_r == act_end)
            addr_nxt = act_start; // see [RULE_17]
          else
            addr_nxt = addr_r + 10'h1;
        end
        default:
        begin
          addr_nxt = addr_r;
        end
      endcase
    end
    else if (state_r == WPS_IDLE && ctrl_r.enable)
      state_nxt = WPS_ARMED;
  end

  // ----------------------------------------------------------------
  // Register bus and update staging
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_stage_r <= WPS_CTRL_RST;
      seg_stage_r[0] <= '{10'h0, 10'h0, WPS_RATE_RST, 3'h0};
      seg_stage_r[1] <= '{10'h0, 10'h0, WPS_RATE_RST, 3'h0};
    end
    else
    begin
      if (wr_ctrl)
        ctrl_stage_r <= reg_wdata;
      if (wr_s0a)
      begin
        seg_stage_r[0].start_addr <= reg_wdata[WPS_SEG_START_LSB +: 10]; // see [RULE_21]
        seg_stage_r[0].end_addr <= reg_wdata[WPS_SEG_END_LSB +: 10];
      end
      if (wr_s0c)
      begin
        seg_stage_r[0].step_rate <= reg_wdata[WPS_SEG_RATE_LSB +: 16];
        seg_stage_r[0].mode <= reg_wdata[WPS_SEG_MODE_LSB +: 3]; // see [RULE_01]
      end
      if (wr_s1a)
      begin
        seg_stage_r[1].start_addr <= reg_wdata[WPS_SEG_START_LSB +: 10];
        seg_stage_r[1].end_addr <= reg_wdata[WPS_SEG_END_LSB +: 10];
      end
      if (wr_s1c)
      begin
        seg_stage_r[1].step_rate <= reg_wdata[WPS_SEG_RATE_LSB +: 16];
        seg_stage_r[1].mode <= reg_wdata[WPS_SEG_MODE_LSB +: 3];
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      WPS_ADDR_CTRL: rd_mux = ctrl_stage_r;
      WPS_ADDR_SEG0_ADDR: rd_mux = {6'h0, seg_stage_r[0].end_addr,
                                    6'h0, seg_stage_r[0].start_addr};
      WPS_ADDR_SEG0_CFG: rd_mux = {13'h0, seg_stage_r[0].mode, seg_stage_r[0].step_rate};
      WPS_ADDR_SEG1_ADDR: rd_mux = {6'h0, seg_stage_r[1].end_addr,
                                    6'h0, seg_stage_r[1].start_addr};
      WPS_ADDR_SEG1_CFG: rd_mux = {13'h0, seg_stage_r[1].mode, seg_stage_r[1].step_rate};
      WPS_ADDR_STATUS: rd_mux = {16'h0, 1'b0, trig_level, state_r, up_r, active_r, addr_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0;
    else if (reg_rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 32'h0;
  end

  // ----------------------------------------------------------------
  // Working state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= '0;
      seg_r[0] <= '{10'h0, 10'h0, WPS_RATE_RST, 3'h0};
      seg_r[1] <= '{10'h0, 10'h0, WPS_RATE_RST, 3'h0};
      state_r <= WPS_IDLE;
      active_r <= 1'b0;
      up_r <= 1'b1;
      addr_r <= 10'h0;
      zero_r <= 1'b0;
    end
    else if (upd)
    begin
      // New settings only take hold here; segment 0 is armed on update
      ctrl_r <= '{ctrl_stage_r[WPS_CTRL_EN_BIT], ctrl_stage_r[WPS_CTRL_DEST_BIT],
                  ctrl_stage_r[WPS_CTRL_OPMODE_LSB +: 2]}; // see [RULE_20]
      seg_r[0] <= seg_stage_r[0];
      seg_r[1] <= seg_stage_r[1];
      active_r <= 1'b0;
      up_r <= 1'b1;
      addr_r <= seg_stage_r[0].start_addr;
      zero_r <= ctrl_stage_r[WPS_CTRL_EN_BIT] & ctrl_stage_r[WPS_CTRL_DEST_BIT]; // see [RULE_22]
      // Bidir, invalid modes and the multiplier destination only arm; other modes start stepping at once
      if (ctrl_stage_r[WPS_CTRL_EN_BIT] && !ctrl_stage_r[WPS_CTRL_DEST_BIT] &&
          seg_stage_r[0].mode != WPS_MODE_BIDIR && mode_valid(seg_stage_r[0].mode))
        state_r <= WPS_RUN; // see [RULE_05] [RULE_18]
      else
        state_r <= ctrl_stage_r[WPS_CTRL_EN_BIT] ? WPS_ARMED : WPS_IDLE; // see [RULE_10]
    end
    else
    begin
      state_r <= state_nxt;
      active_r <= active_nxt;
      up_r <= up_nxt;
      addr_r <= addr_nxt;
      zero_r <= zero_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign ram_addr = addr_r;
  assign ram_rd_en = op_ok && (state_r != WPS_IDLE) && !zero_r;
  assign mult_zero = zero_r;
  assign dest_mult = ctrl_r.dest_mult;
endmodule

// ---- bench/wps_sequencer_monitor.sv ----
`timescale 1ns/1ps
module wps_sequencer_monitor
  import wps_pkg::*;
#(
  parameter int CCI_RATE = WPS_CCI_RATE_DEF,
  parameter int TMR_W = 24
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic io_update,
  input wire logic profile_change,
  input wire logic ram_trigger_pin,
  input wire logic [9:0] ram_addr,
  input wire logic ram_rd_en,
  input wire logic mult_zero,
  input wire logic dest_mult
);
  // ----------------------------------------------------------------
  // Quiet counters
  // ----------------------------------------------------------------
  // Pin edges land several cycles late, so only long quiet spans are judged
  logic pin_r;
  logic [3:0] pq_r;
  logic [3:0] uq_r;
  wire upd = io_update | profile_change;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_r <= 1'b0;
      pq_r <= 4'h0;
      uq_r <= 4'h0;
    end
    else
    begin
      pin_r <= ram_trigger_pin;
      pq_r <= (pin_r != ram_trigger_pin) ? 4'h0 : pq_r + {3'h0, pq_r != 4'hf};
      uq_r <= upd ? 4'h0 : uq_r + {3'h0, uq_r != 4'hf};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_stat_addr;
    reg_rd && reg_addr == WPS_ADDR_STATUS |=> reg_rdata[9:0] == $past(ram_addr);
  endproperty
  a_stat_addr: assert property (p_stat_addr) else $error("status address wrong");
  property p_zero_cause;
    $rose(mult_zero) |-> $past(io_update) || $past(profile_change);
  endproperty
  a_zero_cause: assert property (p_zero_cause) else $error("zero without update");
  property p_zero_dest;
    mult_zero |-> dest_mult;
  endproperty
  a_zero_dest: assert property (p_zero_dest) else $error("zero off multipliers");
  property p_zero_off;
    mult_zero |-> !ram_rd_en;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("reading while zeroed");
  property p_zero_hold;
    mult_zero && !upd && pq_r >= 4'h6 |=> mult_zero;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero left early");
  property p_dest_apply;
    $changed(dest_mult) |-> $past(io_update) || $past(profile_change);
  endproperty
  a_dest_apply: assert property (p_dest_apply) else $error("destination moved");
  // An update in this cycle reloads the address, so it is excluded
  property p_addr_hold;
    !ram_rd_en && !upd && pq_r >= 4'h6 && uq_r >= 4'h3 |=> $stable(ram_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved idle");
  c_step: cover property (ram_rd_en && $changed(ram_addr));
  c_unzero: cover property ($fell(mult_zero));
  c_dest: cover property ($rose(dest_mult));
endmodule

bind wps_sequencer wps_sequencer_monitor #(.CCI_RATE(CCI_RATE), .TMR_W(TMR_W))
  u_wps_sequencer_monitor (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .io_update(io_update), .profile_change(profile_change),
  .ram_trigger_pin(ram_trigger_pin), .ram_addr(ram_addr), .ram_rd_en(ram_rd_en),
  .mult_zero(mult_zero), .dest_mult(dest_mult));

// ---- bench/wps_ctrl_model.sv ----
`timescale 1ns/1ps
module wps_ctrl_model (
  input wire logic clk,
  output logic ram_trigger_pin,
  output logic io_update,
  output logic profile_change
);
  initial
  begin
    ram_trigger_pin = 1'b0;
    io_update = 1'b0;
    profile_change = 1'b0;
  end
  // One-cycle update pulse, either of the two sources
  task automatic update(input logic prof);
    @(posedge clk);
    io_update <= !prof;
    profile_change <= prof;
    @(posedge clk);
    io_update <= 1'b0;
    profile_change <= 1'b0;
  endtask
  task automatic set_pin(input logic lvl);
    @(posedge clk);
    ram_trigger_pin <= lvl;
  endtask
endmodule

// ---- bench/wps_sequencer_tb_top.sv ----
`timescale 1ns/1ps
module wps_sequencer_tb_top;
  import wps_pkg::*;
  // Short multiplier pacing keeps the run brief
  localparam int CCI = 2;
  logic clk, rst_n, reg_wr, reg_rd, io_update, profile_change, ram_trigger_pin;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [9:0] ram_addr;
  logic ram_rd_en, mult_zero, dest_mult;
  int n_mismatch = 0;
  int n_tests = 0;
  int cnt;
  wps_sequencer #(.CCI_RATE(CCI)) u_wps_sequencer (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .io_update(io_update), .profile_change(profile_change),
    .ram_trigger_pin(ram_trigger_pin), .ram_addr(ram_addr), .ram_rd_en(ram_rd_en),
    .mult_zero(mult_zero), .dest_mult(dest_mult));
  wps_ctrl_model u_wps_ctrl_model (.clk(clk), .ram_trigger_pin(ram_trigger_pin),
    .io_update(io_update), .profile_change(profile_change));
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic seg(input int i, input logic [9:0] s, e, input logic [15:0] r,
    input logic [2:0] m);
    wr(4'(WPS_ADDR_SEG0_ADDR + 2 * i), {6'h0, e, 6'h0, s});
    wr(4'(WPS_ADDR_SEG0_CFG + 2 * i), {13'h0, m, r});
  endtask
  task automatic ctrl(input logic dst, input logic [1:0] op);
    wr(WPS_ADDR_CTRL, {28'h0, op, dst, 1'b1});
  endtask
  // Waits a bounded number of cycles for an address, then compares it
  task automatic wait_addr(input logic [9:0] e, input int lim);
    cnt = 0;
    do
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    while (ram_addr !== e && cnt < lim);
    check("ram_addr", {22'h0, ram_addr}, {22'h0, e});
  endtask
  task automatic walk(input logic [9:0] v [6]);
    foreach (v[i]) wait_addr(v[i], 8);
  endtask
  task automatic hold(input logic [9:0] e, input int n);
    repeat (n) wait_addr(e, 1);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #16000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(WPS_ADDR_CTRL, d);
    check("ctrl reset", d, WPS_CTRL_RST);
    rd(WPS_ADDR_SEG0_CFG, d);
    check("cfg reset", d, {16'h0, WPS_RATE_RST});
    wr(4'hf, 32'hffffffff);
    rd(4'hf, d);
    check("unmapped", d, 32'h0);
    seg(0, 10'h10, 10'h14, 16'h1, WPS_MODE_RAMP_UP);
    rd(WPS_ADDR_SEG0_ADDR, d);
    check("seg0 addr", d, 32'h0014_0010);
    $display("test registers done");
    ctrl(1'b0, WPS_OP_QUAD_UPCONVERT);
    u_wps_ctrl_model.update(1'b0);
    for (int k = 'h11; k <= 'h14; k++) wait_addr(10'(k), 8);
    seg(0, 10'h0, 10'h14, 16'h1, WPS_MODE_RAMP_UP);
    hold(10'h14, 6);
    rd(WPS_ADDR_STATUS, d);
    check("status", d, {18'h0, WPS_HALT, 1'b1, 1'b0, 10'h14});
    check("rd_en on", {31'h0, ram_rd_en}, 32'h1);
    $display("test ramp done");
    wr(WPS_ADDR_CTRL, 32'h9);
    u_wps_ctrl_model.update(1'b1);
    hold(10'h0, 4);
    check("rd_en", {31'h0, ram_rd_en}, 32'h0);
    ctrl(1'b0, WPS_OP_INTERP);
    seg(0, 10'h30, 10'h35, 16'h1, 3'h5);
    u_wps_ctrl_model.update(1'b0);
    hold(10'h30, 6);
    $display("test invalid done");
    seg(0, 10'h20, 10'h2a, 16'h1, WPS_MODE_BIDIR);
    seg(1, 10'h40, 10'h45, 16'h1, WPS_MODE_BIDIR);
    u_wps_ctrl_model.update(1'b0);
    hold(10'h20, 6);
    u_wps_ctrl_model.set_pin(1'b1);
    for (int k = 'h21; k <= 'h2a; k++) wait_addr(10'(k), 8);
    hold(10'h2a, 4);
    u_wps_ctrl_model.set_pin(1'b0);
    for (int k = 'h45; k >= 'h40; k--) wait_addr(10'(k), 8);
    hold(10'h40, 4);
    u_wps_ctrl_model.set_pin(1'b1);
    wait_addr(10'h22, 8);
    u_wps_ctrl_model.set_pin(1'b0);
    walk('{10'h45, 10'h44, 10'h43, 10'h42, 10'h41, 10'h40});
    $display("test bidir done");
    seg(0, 10'h50, 10'h52, 16'h1, WPS_MODE_CONT_BIDIR);
    seg(1, 10'h70, 10'h72, 16'h1, WPS_MODE_CONT_BIDIR);
    u_wps_ctrl_model.update(1'b0);
    walk('{10'h51, 10'h52, 10'h51, 10'h50, 10'h51, 10'h52});
    u_wps_ctrl_model.set_pin(1'b1);
    u_wps_ctrl_model.set_pin(1'b0);
    walk('{10'h70, 10'h71, 10'h72, 10'h71, 10'h70, 10'h71});
    $display("test cont bidir done");
    seg(0, 10'h100, 10'h102, 16'h1, WPS_MODE_RECIRC);
    seg(1, 10'h200, 10'h202, 16'h1, WPS_MODE_RAMP_UP);
    u_wps_ctrl_model.update(1'b1);
    walk('{10'h101, 10'h102, 10'h100, 10'h101, 10'h102, 10'h100});
    u_wps_ctrl_model.set_pin(1'b1);
    u_wps_ctrl_model.set_pin(1'b0);
    walk('{10'h200, 10'h201, 10'h202, 10'h202, 10'h202, 10'h202});
    $display("test recirculate done");
    seg(0, 10'h60, 10'h63, 16'h2, WPS_MODE_RAMP_UP);
    ctrl(1'b1, WPS_OP_QUAD_UPCONVERT);
    u_wps_ctrl_model.update(1'b0);
    hold(10'h60, 4);
    check("zeroed", {30'h0, mult_zero, dest_mult}, 32'h3);
    u_wps_ctrl_model.set_pin(1'b1);
    wait_addr(10'h61, 40);
    check("unzeroed", {30'h0, mult_zero, ram_rd_en}, 32'h1);
    wait_addr(10'h62, 40);
    check("step period", cnt, 2 * CCI);
    $display("test multiplier done");
    end_of_test();
  end
endmodule
